// *** rtl/adc_readout_pkg.sv ***
// Overview of operation
// [R1] power-down needs sclk high twenty ready periods
// [R2] after four high periods: three-clock low pulse
// [R3] sixteen more high periods enter power-down; sclk fall wakes
// [R4] first ready pulse 592 clocks after wake
// [R5] results invalid until the sixth ready pulse
// [R6] 24-bit result shifted msb first
// [R7] result coded in two's complement
// [R8] host reads whole word before ready phase
// [R9] ready phase: write, low, high, six each
// [R10] 384-clock cycle, 24-clock high before ready
// [R11] synchronization follows sclk rise within bounds
// [R12] ready phase 2042 clocks after sync release
// [R13] power-down never before 7681 clocks
// [R14] power-down 6143.5 clocks after last ready
// [R15] host discards early words after power-up
// [R16] system clock local; two link wires suffice
// [R17] bits change on sclk fall, sampled rising
// [R18] short read holds bit; long read drives low
// [R19] four to nineteen high periods: modulator sync
// [R20] bit pointer clears at write and pre-ready
// [R21] powered down: no ready pulses, no conversions
//
// package of constants and carrier types for the serial result readout.
// assumes one system clock domain plus the host-driven shift clock.
package adc_readout_pkg;

    localparam int RESULT_W           = 24;   // result width, two's complement
    localparam int CONV_CYCLES        = 384;  // one conversion cycle
    localparam int READY_PHASE_CYCLES = 36;   // ready-signalling phase length
    localparam int SHIFT_PHASE_CYCLES = 348;  // shift phase length
    localparam int WRITE_CYCLES       = 6;    // output register write time
    localparam int LOW_CYCLES         = 6;    // ready low time
    localparam int HIGH_CYCLES        = 6;    // high time before shifting
    localparam int PRE_READY_CYCLES   = 24;   // high time before next ready
    localparam int SYNC_PULSE_CYCLES  = 3;    // low pulse on sync detect
    localparam int SYNC_FRAMES        = 4;    // high periods to detect sync
    localparam int PD_EXTRA_FRAMES    = 16;   // further periods to power down
    localparam int SYNC_RESTART_CLK   = 2042; // 2042.5 clocks, truncated half
    localparam int WAKE_RESTART_CLK   = 592;  // window 591.5 to 592.5 clocks
    localparam int VALID_PULSE        = 6;    // first ready pulse with valid data

    // frame positions derived from the phase lengths
    localparam int LOW_START       = WRITE_CYCLES;
    localparam int HIGH_START      = LOW_START + LOW_CYCLES;
    localparam int SHIFT_START     = HIGH_START + HIGH_CYCLES;
    localparam int PRE_READY_START = CONV_CYCLES - PRE_READY_CYCLES;
    localparam int PD_FRAMES       = SYNC_FRAMES + PD_EXTRA_FRAMES;

    localparam logic [RESULT_W-1:0] RESULT_RESET = 24'h000000;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_SYNC_PULSE,
        ST_SYNC_HOLD,
        ST_POWER_DOWN,
        ST_RESTART
    } ctrl_state_t;

    // converted code from the filter, two's complement
    typedef struct packed {
        logic [RESULT_W-1:0] code;
    } sample_t;

    typedef struct packed {
        logic modulator_reset;   // modulator held in reset
        logic power_down;        // converter powered down
        logic data_settled;      // sixth ready pulse since start reached
    } status_t;

endpackage

// *** rtl/sclk_fall_counter.sv ***
// gray-coded count of shift-clock falling edges, kept in the sclk domain.
// assumes sclk toggles a few times while the system reset is held low.
`timescale 1ns/10ps
`default_nettype none
module sclk_fall_counter #(
    parameter int CNT_W = 4
) (
    input  wire logic             sclk,      // host shift clock
    input  wire logic             reset_n,   // system reset, crossed here
    output logic      [CNT_W-1:0] fall_gray  // gray count of falls
);

    logic             rst_s1_ff;
    logic             rst_s2_ff;
    logic [CNT_W-1:0] bin_ff;
    logic [CNT_W-1:0] nxt_bin;
    logic [CNT_W-1:0] gray_ff;
    logic [CNT_W-1:0] nxt_gray;

    // next count; only one bit of the gray word moves per fall
    always_comb begin
        nxt_bin  = bin_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        nxt_gray = nxt_bin ^ (nxt_bin >> 1);
        if (!rst_s2_ff) begin
            nxt_bin  = '0;
            nxt_gray = '0;
        end
    end

    // [R17] bits advance on falls
    always_ff @(negedge sclk) begin
        rst_s1_ff <= reset_n;
        rst_s2_ff <= rst_s1_ff;
        bin_ff    <= nxt_bin;
        gray_ff   <= nxt_gray;
    end

    assign fall_gray = gray_ff;

endmodule
`default_nettype wire

// *** rtl/adc_readout_ctrl.sv ***
// ready/data line framing, result shift-out, sync and power-down control.
// assumes sys_clk is the local converter clock and sclk comes from the host.
`timescale 1ns/10ps
`default_nettype none
module adc_readout_ctrl #(
    parameter int CNT_W = 4
) (
    input  wire logic                      sys_clk,         // converter clock, 25 MHz
    input  wire logic                      reset_n,         // synchronous reset, active low
    input  wire logic                      sclk,            // host shift clock
    input  wire adc_readout_pkg::sample_t  result_in,       // filter result, sampled at write
    output logic                           ready_data_line, // combined ready/data output
    output adc_readout_pkg::status_t       status           // converter state flags
);

    logic [CNT_W-1:0] fall_gray;
    logic [CNT_W-1:0] gray_s1_ff;
    logic [CNT_W-1:0] gray_s2_ff;
    logic [CNT_W-1:0] bin_prev_ff;
    logic [CNT_W-1:0] bin_now;
    logic             sclk_s1_ff;
    logic             sclk_s2_ff;
    logic             fall_seen;
    logic             sclk_low;

    adc_readout_pkg::ctrl_state_t  state_ff;
    adc_readout_pkg::ctrl_state_t  nxt_state;
    logic [8:0]                    frame_ff;
    logic [8:0]                    nxt_frame;
    logic [11:0]                   wait_ff;
    logic [11:0]                   nxt_wait;
    logic [4:0]                    hi_frames_ff;
    logic [4:0]                    nxt_hi_frames;
    logic [2:0]                    pulse_cnt_ff;
    logic [2:0]                    nxt_pulse_cnt;
    logic                          settled_ff;
    logic                          nxt_settled;
    logic [23:0]                   out_reg_ff;
    logic [23:0]                   nxt_out_reg;
    logic [4:0]                    ptr_ff;
    logic [4:0]                    nxt_ptr;
    logic                          line_ff;
    logic                          nxt_line;

    // [R16] fall counter on the host clock; only its gray word crosses
    sclk_fall_counter #(
        .CNT_W (CNT_W)
    ) u_fall_cnt (
        .sclk      (sclk),
        .reset_n   (reset_n),
        .fall_gray (fall_gray)
    );

    // gray to binary on the second synchroniser stage only
    always_comb begin
        bin_now = '0;
        for (int i = CNT_W - 1; i >= 0; i--) begin
            if (i == CNT_W - 1) begin
                bin_now[i] = gray_s2_ff[i];
            end else begin
                bin_now[i] = bin_now[i+1] ^ gray_s2_ff[i];
            end
        end
    end

    // sclk is slower than sys_clk, so at most one fall shows per cycle
    assign fall_seen = (bin_now != bin_prev_ff);
    // a fall seen or a low level both end a long high period
    assign sclk_low  = !sclk_s2_ff || fall_seen;

    // two-flop synchronisers for the gray count and the sclk level
    always_ff @(posedge sys_clk) begin
        gray_s1_ff  <= fall_gray;
        gray_s2_ff  <= gray_s1_ff;
        bin_prev_ff <= bin_now;
        sclk_s1_ff  <= sclk;
        sclk_s2_ff  <= sclk_s1_ff;
    end

    // next-state of framing, shift pointer and sync/power-down sequencing
    always_comb begin
        nxt_state     = state_ff;
        nxt_frame     = frame_ff;
        nxt_wait      = wait_ff;
        nxt_hi_frames = hi_frames_ff;
        nxt_pulse_cnt = pulse_cnt_ff;
        nxt_settled   = settled_ff;
        nxt_out_reg   = out_reg_ff;
        nxt_ptr       = ptr_ff;
        nxt_line      = 1'b1;
        case (state_ff)
            adc_readout_pkg::ST_RUN: begin
                // [R10] 384-clock conversion cycle
                if (frame_ff == 9'(adc_readout_pkg::CONV_CYCLES - 1)) begin
                    nxt_frame = '0;
                end else begin
                    nxt_frame = frame_ff + 9'h001;
                end
                // [R20] pointer clears at write
                if (frame_ff == 9'h000) begin
                    // [R6] [R7] two's-complement word loaded whole
                    nxt_out_reg = result_in.code;
                    nxt_ptr     = '0;
                end
                // [R20] pointer clears at pre-ready
                if (frame_ff == 9'(adc_readout_pkg::PRE_READY_START)) begin
                    nxt_ptr = '0;
                end
                // [R9] ready phase line shape
                if (frame_ff < 9'(adc_readout_pkg::LOW_START)) begin
                    nxt_line = 1'b1;
                end else if (frame_ff < 9'(adc_readout_pkg::HIGH_START)) begin
                    nxt_line = 1'b0;
                end else if (frame_ff < 9'(adc_readout_pkg::SHIFT_START)) begin
                    nxt_line = 1'b1;
                end else if (frame_ff < 9'(adc_readout_pkg::PRE_READY_START)) begin
                    // [R18] held bit or low after overclock
                    if (ptr_ff < 5'(adc_readout_pkg::RESULT_W)) begin
                        nxt_line = out_reg_ff[5'(adc_readout_pkg::RESULT_W - 1) - ptr_ff];
                    end else begin
                        nxt_line = 1'b0;
                    end
                    // [R17] next bit after each fall
                    if (fall_seen && ptr_ff < 5'(adc_readout_pkg::RESULT_W)) begin
                        nxt_ptr = ptr_ff + 5'h01;
                    end
                end else begin
                    // [R10] 24-clock high before ready
                    nxt_line = 1'b1;
                end
                // [R5] count ready pulses to validity
                if (frame_ff == 9'(adc_readout_pkg::LOW_START)) begin
                    if (pulse_cnt_ff < 3'(adc_readout_pkg::VALID_PULSE)) begin
                        nxt_pulse_cnt = pulse_cnt_ff + 3'h1;
                    end
                    if (pulse_cnt_ff == 3'(adc_readout_pkg::VALID_PULSE - 1)) begin
                        nxt_settled = 1'b1;
                    end
                end
                // [R19] count frame ends while sclk stays high, the partial first frame included
                if (sclk_low) begin
                    nxt_hi_frames = '0;
                end else if (frame_ff == 9'(adc_readout_pkg::CONV_CYCLES - 1)) begin
                    nxt_hi_frames = hi_frames_ff + 5'h01;
                end
                // [R2] [R11] four whole high periods detected
                // the partial frame in which sclk rose also ends once, hence the extra count
                if (!sclk_low && hi_frames_ff == 5'(adc_readout_pkg::SYNC_FRAMES + 1)) begin
                    nxt_state = adc_readout_pkg::ST_SYNC_PULSE;
                    nxt_wait  = 12'h000;
                    nxt_frame = '0;
                    nxt_line  = 1'b0;
                end
            end
            adc_readout_pkg::ST_SYNC_PULSE: begin
                // [R2] three-clock low pulse
                nxt_line = 1'b0;
                nxt_wait = wait_ff + 12'h001;
                if (wait_ff == 12'(adc_readout_pkg::SYNC_PULSE_CYCLES - 1)) begin
                    nxt_state = adc_readout_pkg::ST_SYNC_HOLD;
                    nxt_line  = 1'b1;
                end
            end
            adc_readout_pkg::ST_SYNC_HOLD: begin
                nxt_frame = (frame_ff == 9'(adc_readout_pkg::CONV_CYCLES - 1)) ? 9'h000 : frame_ff + 9'h001;
                if (frame_ff == 9'(adc_readout_pkg::CONV_CYCLES - 1)) begin
                    nxt_hi_frames = hi_frames_ff + 5'h01;
                end
                if (sclk_low) begin
                    // [R12] restart ready phase after sync release
                    nxt_state = adc_readout_pkg::ST_RESTART;
                    nxt_wait  = 12'(adc_readout_pkg::SYNC_RESTART_CLK);
                end else if (hi_frames_ff == 5'(adc_readout_pkg::PD_FRAMES + 1)) begin
                    // [R1] [R3] [R13] [R14] sixteen further periods
                    nxt_state = adc_readout_pkg::ST_POWER_DOWN;
                end
            end
            adc_readout_pkg::ST_POWER_DOWN: begin
                // [R21] silent until sclk falls
                if (sclk_low) begin
                    // [R4] wake delay loaded
                    nxt_state = adc_readout_pkg::ST_RESTART;
                    nxt_wait  = 12'(adc_readout_pkg::WAKE_RESTART_CLK);
                end
            end
            adc_readout_pkg::ST_RESTART: begin
                // [R5] results invalid again
                nxt_hi_frames = '0;
                nxt_pulse_cnt = '0;
                nxt_settled   = 1'b0;
                nxt_wait      = wait_ff - 12'h001;
                if (wait_ff == 12'h001) begin
                    nxt_state = adc_readout_pkg::ST_RUN;
                    nxt_frame = '0;
                end
            end
            default: begin
                nxt_state = adc_readout_pkg::ST_RUN;
            end
        endcase
    end

    // control registers; after reset the first conversion starts at once
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_ff     <= adc_readout_pkg::ST_RUN;
            frame_ff     <= '0;
            wait_ff      <= '0;
            hi_frames_ff <= '0;
            pulse_cnt_ff <= '0;
            settled_ff   <= 1'b0;
            out_reg_ff   <= adc_readout_pkg::RESULT_RESET;
            ptr_ff       <= '0;
            line_ff      <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            frame_ff     <= nxt_frame;
            wait_ff      <= nxt_wait;
            hi_frames_ff <= nxt_hi_frames;
            pulse_cnt_ff <= nxt_pulse_cnt;
            settled_ff   <= nxt_settled;
            out_reg_ff   <= nxt_out_reg;
            ptr_ff       <= nxt_ptr;
            line_ff      <= nxt_line;
        end
    end

    // modulator stays in reset from the sync pulse until sclk falls
    assign ready_data_line = line_ff;
    assign status          = '{
        modulator_reset: (state_ff == adc_readout_pkg::ST_SYNC_PULSE) ||
                         (state_ff == adc_readout_pkg::ST_SYNC_HOLD) ||
                         (state_ff == adc_readout_pkg::ST_POWER_DOWN),
        power_down:      (state_ff == adc_readout_pkg::ST_POWER_DOWN),
        data_settled:    settled_ff
    };

    // ready low lasts exactly six clocks
    a_ready_low_width: assert property ( // [R9]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_RUN && frame_ff == 9'h006 && nxt_state == adc_readout_pkg::ST_RUN)
        |=> !ready_data_line [*6] ##1 ready_data_line
    ) else $error("ready low not six clocks");

    // sync detect gives a three-clock low pulse, then high
    a_sync_pulse_width: assert property ( // [R2]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_RUN && nxt_state == adc_readout_pkg::ST_SYNC_PULSE)
        |=> !ready_data_line [*3] ##1 ready_data_line
    ) else $error("sync pulse not three clocks");

    // frame wraps after 384 clocks
    a_conv_period_wrap: assert property ( // [R10]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_RUN && frame_ff == 9'h17F && nxt_state == adc_readout_pkg::ST_RUN)
        |=> frame_ff == 9'h000
    ) else $error("conversion cycle not 384 clocks");

    // first shift bit after ready is the msb
    a_msb_first_out: assert property ( // [R20]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_RUN && frame_ff == 9'h012 && nxt_state == adc_readout_pkg::ST_RUN)
        |-> ptr_ff == 5'h00 ##1 ready_data_line == out_reg_ff[23]
    ) else $error("shift does not start at msb");

    // overclocked read drives low
    a_overclock_low: assert property ( // [R18]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_RUN && ptr_ff == 5'h18 && frame_ff >= 9'h012 && frame_ff < 9'h168
         && nxt_state == adc_readout_pkg::ST_RUN)
        |=> !ready_data_line
    ) else $error("line not low after 24 falls");

    // power-down only after twenty high periods
    a_pd_entry_count: assert property ( // [R3]
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(status.power_down) |-> $past(hi_frames_ff) == 5'(adc_readout_pkg::PD_FRAMES + 1)
    ) else $error("power-down entered early");

    // first ready pulse after wake lands near 592 clocks
    a_wake_first_ready: assert property ( // [R4]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_POWER_DOWN && sclk_low)
        |-> ##[591:593] (state_ff == adc_readout_pkg::ST_RUN && frame_ff == 9'h000)
    ) else $error("wake ready pulse mistimed");

    // no ready pulses while powered down
    a_pd_line_high: assert property ( // [R21]
        @(posedge sys_clk) disable iff (!reset_n)
        status.power_down && $past(status.power_down) |-> ready_data_line
    ) else $error("line moved in power-down");

    // settled flag rises with the sixth pulse only
    a_settled_sixth: assert property ( // [R5]
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(status.data_settled) |-> pulse_cnt_ff == 3'h6
    ) else $error("settled flag before sixth pulse");

    // modulator released within restart
    a_sync_release: assert property ( // [R19]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_SYNC_HOLD && sclk_low) |=> !status.modulator_reset
    ) else $error("modulator not released on sclk fall");

    // line stays high while the new result is written
    a_write_phase_high: assert property ( // [R9]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_RUN && frame_ff == 9'h000 && nxt_state == adc_readout_pkg::ST_RUN)
        |=> ready_data_line [*6]
    ) else $error("line not high during write");

    // pre-ready interval drives the line high
    a_pre_ready_high: assert property ( // [R10]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_RUN && frame_ff >= 9'h168 && nxt_state == adc_readout_pkg::ST_RUN)
        |=> ready_data_line
    ) else $error("line low before ready phase");

    // pointer cleared as the pre-ready interval starts
    a_ptr_pre_clear: assert property ( // [R20]
        @(posedge sys_clk) disable iff (!reset_n)
        (state_ff == adc_readout_pkg::ST_RUN && frame_ff == 9'h168)
        |=> ptr_ff == 5'h00
    ) else $error("pointer not cleared at pre-ready");

    // a restart makes earlier results invalid again
    a_restart_unsettled: assert property ( // [R5]
        @(posedge sys_clk) disable iff (!reset_n)
        state_ff == adc_readout_pkg::ST_RESTART |=> !status.data_settled
    ) else $error("settled flag kept over restart");

    // line held high while the modulator waits for release
    a_hold_line_high: assert property ( // [R2]
        @(posedge sys_clk) disable iff (!reset_n)
        state_ff == adc_readout_pkg::ST_SYNC_HOLD |-> ready_data_line
    ) else $error("line low while held for sync");

    // sync starts only after whole high periods
    a_sync_start_count: assert property ( // [R11]
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(status.modulator_reset) |-> $past(hi_frames_ff) == 5'(adc_readout_pkg::SYNC_FRAMES + 1)
    ) else $error("sync started early");

endmodule
`default_nettype wire

// *** tb/adc_host_model.sv ***
// host model: drives the shift clock and samples the ready/data line.
// assumes the device clock only paces the idle gap between bits.
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
    input  wire logic sys_clk, // device clock, paces bit gaps
    input  wire logic line_in, // ready/data line from the device
    output logic      sclk     // shift clock toward the device
);
    // idle low: the shift clock moves only in reads, level requests and reset pulses
    initial sclk = 1'b0;

    // two wires only; sample on rise, device shifts on fall
    // gap of 7 clocks a bit keeps a 26-bit read well inside the shift phase
    task automatic shift_bits(input int n, output logic [31:0] word);
        word = 32'h0;
        for (int i = 0; i < n; i++) begin
            #7 sclk = 1'b1;
            word = {word[30:0], line_in};
            #24 sclk = 1'b0;
            repeat (7) @(posedge sys_clk);
        end
    endtask

    // level request: high holds, low releases
    task automatic set_level(input logic v);
        #7 sclk = v;
    endtask

    // toggles during reset so the shift-clock domain clears
    task automatic pulse(input int n);
        repeat (n) begin
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** tb/adc_readout_ctrl_tb_top.sv ***
// self-checking bench for the serial readout, sync and power-down control.
// assumes the host model is the only source of the shift clock.
`timescale 1ns/10ps
`default_nettype none
module adc_readout_ctrl_tb_top;
    logic                     sys_clk = 1'b0;
    logic                     reset_n = 1'b0;
    adc_readout_pkg::sample_t result_in = '{code: 24'h800000};
    wire                      sclk;
    logic                     ready_data_line;
    adc_readout_pkg::status_t status;
    int                       bad_count = 0;
    int                       num_checks = 0;
    logic [31:0]              w;
    int                       n;

    // 25 MHz converter clock
    always #20 sys_clk = ~sys_clk;

    adc_readout_ctrl #(.CNT_W(4)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .sclk(sclk),
        .result_in(result_in), .ready_data_line(ready_data_line), .status(status));
    adc_host_model u_host (.sys_clk(sys_clk), .line_in(ready_data_line), .sclk(sclk));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic in_range(input string what, input int v, input int lo, input int hi);
        check(what, 32'(v >= lo && v <= hi), 32'h1);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // waits for the line high, then counts clocks to the next low
    task automatic wait_ready(output int cnt);
        while (ready_data_line !== 1'b1) @(negedge sys_clk);
        cnt = 0;
        while (ready_data_line !== 1'b0 && cnt < 9000) begin
            @(negedge sys_clk);
            cnt++;
        end
    endtask

    task automatic low_width(output int cnt);
        cnt = 0;
        while (ready_data_line === 1'b0) begin
            @(negedge sys_clk);
            cnt++;
        end
    endtask

    task automatic set_code(input logic [23:0] c);
        @(posedge sys_clk);
        result_in <= '{code: c};
        @(negedge sys_clk);
    endtask

    // reset while the shift clock toggles, so both domains clear
    task automatic t_reset();
        fork
            u_host.pulse(3);
            repeat (3) @(posedge sys_clk);
        join
        @(negedge sys_clk);
        check("line in reset", 32'(ready_data_line), 32'h1);
        check("status in reset", 32'(status), 32'h0);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        // the host-clock side sees the release two falls late; spend them before any read
        u_host.pulse(2);
        $display("reset test done");
    endtask

    task automatic t_codes();
        logic [23:0] codes [4];
        int          k;
        codes = '{24'h7FFFFF, 24'h000000, 24'h800000, 24'hA5C3E1};
        // first frame after reset is skipped
        wait_ready(n);
        low_width(k);
        foreach (codes[i]) begin
            set_code(codes[i]);
            wait_ready(n);
            low_width(k);
            check("ready low clocks", 32'(k), 32'(adc_readout_pkg::LOW_CYCLES));
            repeat (7) @(negedge sys_clk);
            u_host.shift_bits(24, w);
            check("result word", w, {8'h00, codes[i]});
        end
        $display("codes test done");
    endtask

    // short read, long read, pre-ready and frame spacing
    task automatic t_frame();
        int k;
        set_code(24'hC05FFF);
        wait_ready(n);
        low_width(k);
        repeat (7) @(negedge sys_clk);
        u_host.shift_bits(10, w);
        check("short read bits", w, 32'h301);
        low_width(k);
        check("last bit held", 32'(k > 200), 32'h1);
        wait_ready(n);
        check("pre-ready to low", 32'(n), 32'(adc_readout_pkg::PRE_READY_CYCLES + 6));
        low_width(k);
        repeat (7) @(negedge sys_clk);
        u_host.shift_bits(26, w);
        check("long read bits", w, 32'h3017FFC);
        low_width(k);
        check("line low after word", 32'(k > 100), 32'h1);
        wait_ready(n);
        low_width(k);
        wait_ready(n);
        check("frame spacing", 32'(n), 32'(adc_readout_pkg::CONV_CYCLES - 6));
        low_width(k);
        $display("frame test done");
    endtask

    // holds the shift clock high until the 3-clock pulse appears
    task automatic hold_to_pulse(output int p);
        int k;
        p = 0;
        u_host.set_level(1'b1);
        do begin
            wait_ready(n);
            low_width(k);
            p++;
        end while (k != 3 && p < 8);
        check("sync pulse clocks", 32'(k), 32'(adc_readout_pkg::SYNC_PULSE_CYCLES));
        check("modulator reset set", 32'(status.modulator_reset), 32'h1);
    endtask

    task automatic t_sync();
        int p;
        int k;
        hold_to_pulse(p);
        check("pulses up to sync", 32'(p), 32'h5);
        k = 1;
        repeat (768) begin
            @(negedge sys_clk);
            if (ready_data_line !== 1'b1 || status.power_down !== 1'b0) k = 0;
        end
        check("held high, no power-down", 32'(k), 32'h1);
        u_host.set_level(1'b0);
        wait_ready(n);
        in_range("sync restart", n, 2046, 2058);
        check("modulator released", 32'(status.modulator_reset), 32'h0);
        check("settled cleared", 32'(status.data_settled), 32'h0);
        low_width(k);
        $display("sync test done");
    endtask

    task automatic t_pd();
        int  p;
        int  k;
        time t0;
        t0 = $time;
        hold_to_pulse(p);
        k = 1;
        n = 0;
        while (status.power_down !== 1'b1 && n < 7000) begin
            @(negedge sys_clk);
            n++;
            if (ready_data_line !== 1'b1) k = 0;
        end
        in_range("pulse to power-down", n, 6136, 6148);
        check("no pulses while down", 32'(k), 32'h1);
        check("not before limit", 32'(($time - t0) / 40 >= 7681), 32'h1);
        check("modulator held", 32'(status.modulator_reset), 32'h1);
        u_host.set_level(1'b0);
        wait_ready(n);
        in_range("wake to ready", n, 596, 608);
        check("woken", 32'(status.power_down), 32'h0);
        low_width(k);
        repeat (4) begin
            wait_ready(n);
            check("cadence after wake", 32'(n), 32'(adc_readout_pkg::CONV_CYCLES - 6));
            low_width(k);
        end
        check("fifth pulse unsettled", 32'(status.data_settled), 32'h0);
        wait_ready(n);
        low_width(k);
        check("sixth pulse settled", 32'(status.data_settled), 32'h1);
        $display("power-down test done");
    endtask

    initial begin
        t_reset();
        t_codes();
        t_frame();
        t_sync();
        t_pd();
        summarize();
    end

    // watchdog: roughly twice the expected run length
    initial begin
        #(40000 * 40);
        bad_count++;
        $display("Error watchdog expected finish seen timeout");
        summarize();
    end
endmodule
`default_nettype wire
